/* File: common/sregc_defs.svh */
// Offsets, field positions, reset values and rail figures of the
// supply regulator control block.
// Assumes a 32-bit AXI4-Lite register window with byte addressing.
`ifndef SREGC_DEFS_SVH
`define SREGC_DEFS_SVH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define SREGC_CSC_IDX 8'h00
`define SREGC_RIC_IDX 8'h0B
`define SREGC_CSC_ADDR 8'h00
`define SREGC_RIC_ADDR 8'h2C
`define SREGC_STAT_ADDR 8'h30

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define SREGC_CSC_SUPPLY_BIT 0
`define SREGC_CSC_STANDBY_BIT 7
`define SREGC_RIC_AUTO_BIT 7
`define SREGC_CSC_RESET 8'h01
`define SREGC_RIC_RESET 8'h83

// ****************************************************************
// Rail figures in millivolts
// ****************************************************************
`define SREGC_RF_CAP_MV 13'h1388
`define SREGC_AX_CAP_MV 13'h0D48
`define SREGC_MAN5_BASE_MV 13'h10CC
`define SREGC_MAN3_BASE_MV 13'h0A8C
`define SREGC_STEP_MV 13'h0064
`define SREGC_MARGIN_250_MV 13'h00FA
`define SREGC_MARGIN_350_MV 13'h015E
`define SREGC_MARGIN_400_MV 13'h0190

`endif

/* File: common/sregc_pkg.sv */
// Types shared by the supply regulator control block.
// Assumes the constants header is compiled alongside.
package sregc_pkg;

   // One-hot states of the automatic setting run
   typedef enum logic [2:0] {
      SREGC_IDLE = 3'b001,
      SREGC_SAMPLE = 3'b010,
      SREGC_APPLY = 3'b100
   } sregc_state_t;

   // AXI4-Lite response codes
   typedef enum logic [1:0] {
      SREGC_OKAY = 2'b00,
      SREGC_SLVERR = 2'b10
   } sregc_resp_t;

endpackage

/* File: rtl/sregc_top.sv */
// Supply regulator control: supply mode, regulator mode, rail targets
// and enable gating, with an AXI4-Lite register slave.
// Assumes INPUT_SUPPLY_MV_I comes from a monitor on REF_CLK_I and the
// two enable pins arrive asynchronously from outside.
//
// What this block does
// [RQ1] Bit 0 of the chip status control register picks 5-V or 3-V.
// [RQ2] After reset that bit reads as the 5-V configuration.
// [RQ3] Software ought to pick 3-V when the input supply is below 4.3 V.
// [RQ4] Bit 7 of regulator control picks automatic (1) or manual (0).
// [RQ5] In automatic mode bits 1:0 pick a 250, 350 or 400 mV margin.
// [RQ6] Manual 5-V: RF rail 4.3 V to 5 V by code, other rails 3.4 V.
// [RQ7] Manual 3-V: all three rails 2.7 V to 3.4 V by the same code.
// [RQ8] Automatic targets sit below the input, capped 5 V and 3.4 V.
// [RQ9] Power state follows both enable pins and chip status bit 7 (standby).
// [RQ10] Main enable high turns on rails, oscillator and host clock.
// [RQ11] Software ought to write 0x87 for the usual automatic setting.
// [RQ12] Automatic setting runs on main enable rise and mode bit 0-to-1.
// [RQ13] A mode or code write reaches the rail outputs one cycle later.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sregc_defs.svh"

module sregc_top
   import sregc_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic MAIN_ENABLE_I,
   input wire logic SECONDARY_WAKE_PIN_I,
   input wire logic [12:0] INPUT_SUPPLY_MV_I,
   output logic [12:0] RF_AMPLIFIER_RAIL_MV_O,
   output logic [12:0] ANALOG_RAIL_MV_O,
   output logic [12:0] DIGITAL_RAIL_MV_O,
   output logic RF_AMPLIFIER_RAIL_EN_O,
   output logic ANALOG_RAIL_EN_O,
   output logic DIGITAL_RAIL_EN_O,
   output logic OSC_EN_O,
   output logic HOST_CLOCK_OUTPUT_EN_O,
   output logic HOST_CLOCK_AUX_SEL_O,
   output logic SUPPLY_5V_MODE_O
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0] chip_status, regulator_io_control, aw_addr;
   logic aw_have, w_have, wr_fire, en_prev, auto_prev, auto_trigger, rd_hit;
   logic [31:0] w_data, rd_data;
   logic [3:0] w_strb;
   logic [1:0] en_meta, wake_meta;
   sregc_state_t state, next_state;
   logic [12:0] vin_snap, margin_snap, auto_rf, auto_ax;
   logic [12:0] next_rf, next_ax, target, margin_sel;

   // ****************************************************************
   // Write channel: address and data taken in either order
   // ****************************************************************
   // Ready falls on the handshake, rises after the response: one write
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         S_AXI_AWREADY_O <= 1'b0;
      end else if (S_AXI_AWREADY_O && S_AXI_AWVALID_I) begin
         S_AXI_AWREADY_O <= 1'b0;
      end else if (!aw_have && !S_AXI_BVALID_O) begin
         S_AXI_AWREADY_O <= 1'b1;
      end
   end
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         S_AXI_WREADY_O <= 1'b0;
      end else if (S_AXI_WREADY_O && S_AXI_WVALID_I) begin
         S_AXI_WREADY_O <= 1'b0;
      end else if (!w_have && !S_AXI_BVALID_O) begin
         S_AXI_WREADY_O <= 1'b1;
      end
   end
   // Hold the taken address and data until both are present
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         aw_have <= 1'b0;
         aw_addr <= 8'h00;
      end else if (S_AXI_AWREADY_O && S_AXI_AWVALID_I) begin
         aw_have <= 1'b1;
         aw_addr <= S_AXI_AWADDR_I;
      end else if (wr_fire) begin
         aw_have <= 1'b0;
      end
   end
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         w_have <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (S_AXI_WREADY_O && S_AXI_WVALID_I) begin
         w_have <= 1'b1;
         w_data <= S_AXI_WDATA_I;
         w_strb <= S_AXI_WSTRB_I;
      end else if (wr_fire) begin
         w_have <= 1'b0;
      end
   end
   assign wr_fire = aw_have && w_have && !S_AXI_BVALID_O;
   // Response one cycle after the write; unmapped addresses error out
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= SREGC_OKAY;
      end else if (wr_fire) begin
         S_AXI_BVALID_O <= 1'b1;
         if (aw_addr == `SREGC_CSC_ADDR || aw_addr == `SREGC_RIC_ADDR) begin
            S_AXI_BRESP_O <= SREGC_OKAY;
         end else begin
            S_AXI_BRESP_O <= SREGC_SLVERR;
         end
      end else if (S_AXI_BREADY_I) begin
         S_AXI_BVALID_O <= 1'b0;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Only the low byte lane carries register bits
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         chip_status <= `SREGC_CSC_RESET; // RQ2
      end else if (wr_fire && w_strb[0] && aw_addr == `SREGC_CSC_ADDR) begin
         chip_status <= w_data[7:0]; // RQ1
      end
   end
   // Bits 6:3 are stored but steer nothing
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         regulator_io_control <= `SREGC_RIC_RESET;
      end else if (wr_fire && w_strb[0] && aw_addr == `SREGC_RIC_ADDR) begin
         regulator_io_control <= w_data[7:0]; // RQ4
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   // Read decode; status word shows the pins and the live RF target
   always_comb begin
      rd_hit = 1'b1;
      rd_data = 32'h0000_0000;
      if (S_AXI_ARADDR_I == `SREGC_CSC_ADDR) begin
         rd_data = {24'h00_0000, chip_status};
      end else if (S_AXI_ARADDR_I == `SREGC_RIC_ADDR) begin
         rd_data = {24'h00_0000, regulator_io_control};
      end else if (S_AXI_ARADDR_I == `SREGC_STAT_ADDR) begin
         rd_data = {3'b000, RF_AMPLIFIER_RAIL_MV_O, 12'h000,
                    regulator_io_control[`SREGC_RIC_AUTO_BIT],
                    wake_meta[1], en_meta[1], (state != SREGC_IDLE)};
      end else begin
         rd_hit = 1'b0;
      end
   end
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         S_AXI_ARREADY_O <= 1'b0;
      end else if (S_AXI_ARREADY_O && S_AXI_ARVALID_I) begin
         S_AXI_ARREADY_O <= 1'b0;
      end else if (!S_AXI_RVALID_O) begin
         S_AXI_ARREADY_O <= 1'b1;
      end
   end
   // Data captured at the address handshake, valid the next cycle
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h0000_0000;
         S_AXI_RRESP_O <= SREGC_OKAY;
      end else if (S_AXI_ARREADY_O && S_AXI_ARVALID_I) begin
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RDATA_O <= rd_data;
         S_AXI_RRESP_O <= rd_hit ? SREGC_OKAY : SREGC_SLVERR;
      end else if (S_AXI_RREADY_I) begin
         S_AXI_RVALID_O <= 1'b0;
      end
   end

   // ****************************************************************
   // Enable pin synchronisers and trigger detection
   // ****************************************************************
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         en_meta <= 2'b00;
         wake_meta <= 2'b00;
      end else begin
         en_meta <= {en_meta[0], MAIN_ENABLE_I};
         wake_meta <= {wake_meta[0], SECONDARY_WAKE_PIN_I};
      end
   end
   // Previous values; the mode bit resets high so reset is no 0-to-1
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         en_prev <= 1'b0;
         auto_prev <= 1'b1;
      end else begin
         en_prev <= en_meta[1];
         auto_prev <= regulator_io_control[`SREGC_RIC_AUTO_BIT];
      end
   end
   // Rerun on main enable rise, or with the mode bit written 1, 0, 1
   assign auto_trigger = (en_meta[1] && !en_prev) ||
      (regulator_io_control[`SREGC_RIC_AUTO_BIT] && !auto_prev); // RQ12

   // ****************************************************************
   // Automatic setting run
   // ****************************************************************
   // Margin by code; 01 is not a listed code and takes the 350 mV step
   always_comb begin
      case (regulator_io_control[1:0])
         2'b11: margin_sel = `SREGC_MARGIN_250_MV; // RQ5
         2'b00: margin_sel = `SREGC_MARGIN_400_MV;
         default: margin_sel = `SREGC_MARGIN_350_MV;
      endcase
   end
   always_comb begin
      next_state = state;
      case (state)
         SREGC_IDLE: begin
            if (auto_trigger) begin
               next_state = SREGC_SAMPLE;
            end
         end
         SREGC_SAMPLE: next_state = SREGC_APPLY;
         SREGC_APPLY: next_state = SREGC_IDLE;
         default: next_state = SREGC_IDLE;
      endcase
   end
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state <= SREGC_IDLE;
      end else begin
         state <= next_state;
      end
   end
   // Snapshot input and margin so a mid-run write cannot tear the result
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         vin_snap <= 13'h0000;
         margin_snap <= `SREGC_MARGIN_250_MV;
      end else if (state == SREGC_SAMPLE) begin
         vin_snap <= INPUT_SUPPLY_MV_I;
         margin_snap <= margin_sel;
      end
   end
   // Target below the input, floored at zero for a collapsed supply
   assign target = (vin_snap > margin_snap) ?
      vin_snap - margin_snap : 13'h0000;
   // Results held until the next run, capped per rail
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         auto_rf <= 13'h0000;
         auto_ax <= 13'h0000;
      end else if (state == SREGC_APPLY) begin
         auto_rf <= (target > `SREGC_RF_CAP_MV) ?
            `SREGC_RF_CAP_MV : target; // RQ8
         auto_ax <= (target > `SREGC_AX_CAP_MV) ?
            `SREGC_AX_CAP_MV : target; // RQ8
      end
   end

   // ****************************************************************
   // Rail target selection
   // ****************************************************************
   always_comb begin
      if (regulator_io_control[`SREGC_RIC_AUTO_BIT]) begin
         next_rf = auto_rf; // RQ4
         next_ax = auto_ax;
      end else if (chip_status[`SREGC_CSC_SUPPLY_BIT]) begin
         next_rf = `SREGC_MAN5_BASE_MV +
            {10'h000, regulator_io_control[2:0]} * `SREGC_STEP_MV; // RQ6
         next_ax = `SREGC_AX_CAP_MV; // RQ6
      end else begin
         next_rf = `SREGC_MAN3_BASE_MV +
            {10'h000, regulator_io_control[2:0]} * `SREGC_STEP_MV; // RQ7
         next_ax = next_rf; // RQ7
      end
   end
   // Registered once, so a register write shows one cycle later
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RF_AMPLIFIER_RAIL_MV_O <= 13'h0000;
         ANALOG_RAIL_MV_O <= 13'h0000;
         DIGITAL_RAIL_MV_O <= 13'h0000;
         SUPPLY_5V_MODE_O <= 1'b1;
      end else begin
         RF_AMPLIFIER_RAIL_MV_O <= next_rf; // RQ13
         ANALOG_RAIL_MV_O <= next_ax; // RQ13
         DIGITAL_RAIL_MV_O <= next_ax; // RQ13
         SUPPLY_5V_MODE_O <= chip_status[`SREGC_CSC_SUPPLY_BIT]; // RQ1
      end
   end

   // ****************************************************************
   // Power gating
   // ****************************************************************
   // Main runs all, standby parks RF; wake alone keeps digital, slow clock
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RF_AMPLIFIER_RAIL_EN_O <= 1'b0;
         ANALOG_RAIL_EN_O <= 1'b0;
         DIGITAL_RAIL_EN_O <= 1'b0;
         OSC_EN_O <= 1'b0;
         HOST_CLOCK_OUTPUT_EN_O <= 1'b0;
         HOST_CLOCK_AUX_SEL_O <= 1'b0;
      end else begin
         RF_AMPLIFIER_RAIL_EN_O <= en_meta[1] &&
            !chip_status[`SREGC_CSC_STANDBY_BIT]; // RQ9
         ANALOG_RAIL_EN_O <= en_meta[1]; // RQ10
         DIGITAL_RAIL_EN_O <= en_meta[1] || wake_meta[1]; // RQ9
         OSC_EN_O <= en_meta[1]; // RQ10
         HOST_CLOCK_OUTPUT_EN_O <= en_meta[1] || wake_meta[1]; // RQ10
         HOST_CLOCK_AUX_SEL_O <= !en_meta[1] && wake_meta[1]; // RQ9
      end
   end

endmodule

/* File: verif/sregc_assertions.sv */
// Checker for the supply regulator control block.
// Assumes it is bound to sregc_top and sees only that module's ports.
`timescale 1ns/1ps

module sregc_checker (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic MAIN_ENABLE_I,
   input wire logic SECONDARY_WAKE_PIN_I,
   input wire logic [12:0] RF_AMPLIFIER_RAIL_MV_O,
   input wire logic [12:0] ANALOG_RAIL_MV_O,
   input wire logic [12:0] DIGITAL_RAIL_MV_O,
   input wire logic RF_AMPLIFIER_RAIL_EN_O,
   input wire logic ANALOG_RAIL_EN_O,
   input wire logic DIGITAL_RAIL_EN_O,
   input wire logic OSC_EN_O,
   input wire logic HOST_CLOCK_OUTPUT_EN_O,
   input wire logic HOST_CLOCK_AUX_SEL_O
);
   // ****************
   // Checks
   // ****************
   // One clock domain, so one default clock and reset
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   // Pin outputs lag the pins by two sync flops and one output flop
   osc_follow_a: assert property (
      OSC_EN_O == $past(MAIN_ENABLE_I, 3) && ANALOG_RAIL_EN_O == OSC_EN_O)
      else $error("oscillator enable does not follow main enable");
   host_clock_a: assert property (
      HOST_CLOCK_OUTPUT_EN_O == ($past(MAIN_ENABLE_I, 3) ||
      $past(SECONDARY_WAKE_PIN_I, 3)) &&
      DIGITAL_RAIL_EN_O == HOST_CLOCK_OUTPUT_EN_O)
      else $error("host clock or digital rail enable wrong");
   aux_clock_a: assert property (
      HOST_CLOCK_AUX_SEL_O == ($past(SECONDARY_WAKE_PIN_I, 3) &&
      !$past(MAIN_ENABLE_I, 3)))
      else $error("auxiliary clock select wrong");
   rf_gate_a: assert property (
      RF_AMPLIFIER_RAIL_EN_O |-> ANALOG_RAIL_EN_O)
      else $error("rf rail on while main enable is off");
   rails_tie_a: assert property (
      DIGITAL_RAIL_MV_O == ANALOG_RAIL_MV_O)
      else $error("digital and analog rails differ");
   rail_cap_a: assert property (
      RF_AMPLIFIER_RAIL_MV_O <= 13'h1388 && ANALOG_RAIL_MV_O <= 13'h0D48)
      else $error("rail target above its cap");
   write_answer_a: assert property (
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I &&
      S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O)
      else $error("write response late");
   resp_hold_a: assert property (
      S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
      S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped before taken");
   read_answer_a: assert property (
      S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read data late");
endmodule

bind sregc_top sregc_checker u_chk (.*);

/* File: verif/sregc_host_model.sv */
// Host model: drives the two enable pins and the input supply level.
// Assumes the bench calls its task from a single process.
`timescale 1ns/1ps

module sregc_host_model (
   input wire logic clk_i,
   output logic main_o,
   output logic wake_o,
   output logic [12:0] vin_o
);
   // Usual automatic setting with the 250 mV margin
   localparam logic [7:0] AUTO_USUAL = 8'h87;
   // Pins idle low, so the block starts powered down
   initial begin
      main_o = 1'b0;
      wake_o = 1'b0;
      vin_o = 13'h0FA0;
   end
   // Pins change just after an edge, like an external host
   task automatic pins(input logic m, input logic w, input logic [12:0] v);
      @(posedge clk_i);
      main_o <= m;
      wake_o <= w;
      vin_o <= v;
   endtask
   // Register value software normally writes for automatic mode
   function automatic logic [7:0] usual_ric();
      return AUTO_USUAL;
   endfunction
   // Below 4.3 V the 3-V configuration is the safe choice
   function automatic logic [7:0] csc_for(input logic [12:0] v);
      return (v < 13'h10CC) ? 8'h00 : 8'h01;
   endfunction
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the supply regulator control block.
// Assumes sregc_top, the host model and the checker are compiled first.
`timescale 1ns/1ps
`include "sregc_defs.svh"

module tb_top;
   logic REF_CLK_I = 1'b0;
   logic RST_I = 1'b1;
   logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
   logic [31:0] S_AXI_WDATA_I = 32'h0000_0000, S_AXI_RDATA_O;
   logic [3:0] S_AXI_WSTRB_I = 4'hF;
   logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0;
   logic S_AXI_BREADY_I = 1'b0, S_AXI_ARVALID_I = 1'b0;
   logic S_AXI_RREADY_I = 1'b0, S_AXI_AWREADY_O, S_AXI_WREADY_O;
   logic S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
   logic MAIN_ENABLE_I, SECONDARY_WAKE_PIN_I, SUPPLY_5V_MODE_O;
   logic [12:0] INPUT_SUPPLY_MV_I, RF_AMPLIFIER_RAIL_MV_O;
   logic [12:0] ANALOG_RAIL_MV_O, DIGITAL_RAIL_MV_O;
   logic RF_AMPLIFIER_RAIL_EN_O, ANALOG_RAIL_EN_O, DIGITAL_RAIL_EN_O;
   logic OSC_EN_O, HOST_CLOCK_OUTPUT_EN_O, HOST_CLOCK_AUX_SEL_O;
   int error_cnt = 0, num_checks = 0, v, s, c;
   int mg[3] = '{250, 350, 400};
   logic [7:0] ric[3] = '{8'h87, 8'h82, 8'h80};
   logic [33:0] exp_q[$];
   wire [5:0] pwr = {OSC_EN_O, ANALOG_RAIL_EN_O, DIGITAL_RAIL_EN_O,
      RF_AMPLIFIER_RAIL_EN_O, HOST_CLOCK_OUTPUT_EN_O, HOST_CLOCK_AUX_SEL_O};

   // ****************
   // Clock, design and host
   // ****************
   always #4 REF_CLK_I = ~REF_CLK_I;
   sregc_top dut (.*);
   sregc_host_model host (
      .clk_i(REF_CLK_I),
      .main_o(MAIN_ENABLE_I),
      .wake_o(SECONDARY_WAKE_PIN_I),
      .vin_o(INPUT_SUPPLY_MV_I)
   );

   // Compare and count
   task automatic chk(input string n, input logic [33:0] e,
      input logic [33:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // Verdict and end of run
   task automatic close_out();
      $display("Checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Each bus answer is matched with the oldest expectation
   always @(posedge REF_CLK_I) begin
      if (S_AXI_RVALID_O && S_AXI_RREADY_I)
         chk("read", exp_q.pop_front(), {S_AXI_RRESP_O, S_AXI_RDATA_O});
      if (S_AXI_BVALID_O && S_AXI_BREADY_I)
         chk("write", exp_q.pop_front(), {S_AXI_BRESP_O, 32'h0000_0000});
   end
   // Write: both channels offered together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] r);
      exp_q.push_back({r, 32'h0000_0000});
      @(posedge REF_CLK_I);
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= {24'($urandom), d};
      S_AXI_AWVALID_I <= 1'b1;
      S_AXI_WVALID_I <= 1'b1;
      S_AXI_BREADY_I <= 1'b1;
      do begin
         @(posedge REF_CLK_I);
         if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
         if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
      end while ((S_AXI_AWVALID_I && !S_AXI_AWREADY_O) ||
         (S_AXI_WVALID_I && !S_AXI_WREADY_O));
      while (!S_AXI_BVALID_O) @(posedge REF_CLK_I);
      S_AXI_BREADY_I <= 1'b0;
   endtask
   // Read: address held until taken, rready held until data seen
   task automatic axr(input logic [7:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      @(posedge REF_CLK_I);
      S_AXI_ARADDR_I <= a;
      S_AXI_ARVALID_I <= 1'b1;
      S_AXI_RREADY_I <= 1'b1;
      do @(posedge REF_CLK_I); while (!S_AXI_ARREADY_O);
      S_AXI_ARVALID_I <= 1'b0;
      do @(posedge REF_CLK_I); while (!S_AXI_RVALID_O);
      S_AXI_RREADY_I <= 1'b0;
   endtask
   // Rails after an auto run has surely finished
   task automatic rails(input int rf, input int ax);
      repeat (8) @(posedge REF_CLK_I);
      chk("rf_rail", 34'(rf), 34'(RF_AMPLIFIER_RAIL_MV_O));
      chk("analog_rail", 34'(ax), 34'(ANALOG_RAIL_MV_O));
      chk("digital_rail", 34'(ax), 34'(DIGITAL_RAIL_MV_O));
   endtask
   function automatic int cap(input int x, input int m);
      return (x > m) ? m : x;
   endfunction

   // Reset, then registers, manual codes, auto runs and power states
   initial begin
      void'($urandom(32'h8138_4472));
      repeat (20) @(posedge REF_CLK_I);
      RST_I <= 1'b0;
      axr(`SREGC_CSC_ADDR, 34'h0_0000_0001);
      axr(`SREGC_RIC_ADDR, 34'h0_0000_0083);
      axr(8'h3C, 34'h2_0000_0000);
      axw(8'h3C, 8'h5A, 2'b10);
      for (s = 1; s >= 0; s--) begin
         axw(`SREGC_CSC_ADDR, 8'(s), 2'b00);
         for (c = 0; c < 8; c++) begin
            axw(`SREGC_RIC_ADDR, {1'b0, 4'($urandom), 3'(c)}, 2'b00);
            v = (s == 1) ? 4300 + 100 * c : 2700 + 100 * c;
            #1 chk("rf_next", 34'(v), 34'(RF_AMPLIFIER_RAIL_MV_O));
            rails(v, (s == 1) ? 3400 : v);
         end
         chk("mode_5v", 34'(s), 34'(SUPPLY_5V_MODE_O));
      end
      // Manual first, then the auto bit rises for each margin
      ric[0] = host.usual_ric();
      for (c = 0; c < 3; c++) begin
         v = (c == 0) ? 5400 : 3000 + $urandom % 2000;
         host.pins(1'b0, 1'b0, 13'(v));
         axw(`SREGC_CSC_ADDR, host.csc_for(13'(v)), 2'b00);
         axw(`SREGC_RIC_ADDR, ric[c] & 8'h7F, 2'b00);
         axw(`SREGC_RIC_ADDR, ric[c], 2'b00);
         rails(cap(v - mg[c], 5000), cap(v - mg[c], 3400));
      end
      axr(`SREGC_RIC_ADDR, 34'h0_0000_0080);
      // Auto bit written 1 again: no rerun
      host.pins(1'b0, 1'b0, 13'(v + 100));
      axw(`SREGC_RIC_ADDR, 8'h80, 2'b00);
      rails(cap(v - 400, 5000), cap(v - 400, 3400));
      // Main enable rising reruns with the new input level
      host.pins(1'b1, 1'b0, 13'(v + 100));
      rails(cap(v - 300, 5000), cap(v - 300, 3400));
      chk("power_on", 34'h3E, 34'(pwr));
      axr(`SREGC_STAT_ADDR, (34'(cap(v - 300, 5000)) << 16) | 34'hA);
      axw(`SREGC_CSC_ADDR, 8'h81, 2'b00);
      repeat (4) @(posedge REF_CLK_I);
      chk("standby", 34'h3A, 34'(pwr));
      host.pins(1'b0, 1'b1, 13'(v + 100));
      repeat (6) @(posedge REF_CLK_I);
      chk("wake_only", 34'h0B, 34'(pwr));
      close_out();
   end
   // Whole run needs well under 5000 cycles
   initial begin
      #(8 * 20000);
      error_cnt++;
      $display("CHECK FAILED watchdog expected end seen hang");
      close_out();
   end
endmodule
